// [ebh_pkg.sv]
// constants shared by both ends of the bus hold link
// Summary of operation
// RULE_01: master holds request high while needing bus
// RULE_02: master drops request when transfers finish
// RULE_03: grant goes 1 when bus released
// RULE_04: grant goes 0 when bus retaken
// RULE_05: direction high on read, low write
// RULE_06: direction changes with address timing
// RULE_07: direction is master input when not owner
// RULE_08: owner drives output enable low on reads
// RULE_09: output enable placed per bank timing
// RULE_10: output enable pin carries size bit one
// RULE_11: ready low inserts wait states
// RULE_12: ready honoured only for ready-enabled banks
// RULE_13: reset pin low eight cycles starts reset
// RULE_14: device drives reset pin low eight cycles
// RULE_15: priority input sets hold request priority
// RULE_16: dma3 pin carries size bit zero
// RULE_17: grant only at transaction boundary
package ebh_pkg;
  localparam int unsigned EBH_ADDR_W = 32;
  localparam int unsigned EBH_BANKS = 8;
  localparam int unsigned EBH_BANK_W = 3;
  localparam int unsigned EBH_OE_DLY_W = 2;
  localparam logic [3:0] EBH_RST_CYCLES = 4'h8;
  localparam logic [3:0] EBH_RST_CNT_MAX = 4'hF;
  localparam logic [EBH_BANKS-1:0] EBH_RDY_EN_RST = 8'h00;
  localparam logic [EBH_OE_DLY_W*EBH_BANKS-1:0] EBH_OE_DLY_RST = 16'h0000;
endpackage

// [ebh_if.sv]
// pin-level link between device and external bus master
interface ebh_if;
  logic bus_hold_request;
  logic bus_hold_grant;
  logic [31:0] addr_dev;
  logic addr_dev_oe;
  logic rw_dev;
  logic rw_dev_oe;
  logic rw_mst;
  logic rw_mst_oe;
  logic oe_n_dev;
  logic oe_n_dev_oe;
  logic oe_mst;
  logic oe_mst_oe;
  logic dma3_dev;
  logic dma3_dev_oe;
  logic dma3_mst;
  logic dma3_mst_oe;
  logic ready;
  logic rst_pin_dev;
  logic rst_pin_dev_oe;
  logic rst_pin_mst;
  logic rst_pin_mst_oe;
  logic rw_pin;
  logic oe_pin;
  logic dma3_pin;
  logic rst_pin;
  // wire resolution from the enables; pull-ups idle high
  assign rw_pin = rw_dev_oe ? rw_dev : (rw_mst_oe ? rw_mst : 1'b1);
  assign oe_pin = oe_n_dev_oe ? oe_n_dev : (oe_mst_oe ? oe_mst : 1'b1);
  assign dma3_pin = dma3_dev_oe ? dma3_dev : (dma3_mst_oe ? dma3_mst : 1'b1);
  assign rst_pin = (rst_pin_dev_oe && !rst_pin_dev) || (rst_pin_mst_oe && !rst_pin_mst) ? 1'b0 : 1'b1;
  modport dev (
    input bus_hold_request, ready, rw_pin, oe_pin, dma3_pin, rst_pin,
    output bus_hold_grant, addr_dev, addr_dev_oe, rw_dev, rw_dev_oe, oe_n_dev, oe_n_dev_oe,
    output dma3_dev, dma3_dev_oe, rst_pin_dev, rst_pin_dev_oe
  );
  modport mst (
    input bus_hold_grant, rw_pin, oe_pin, dma3_pin, rst_pin,
    output bus_hold_request, rw_mst, rw_mst_oe, oe_mst, oe_mst_oe, dma3_mst, dma3_mst_oe,
    output ready, rst_pin_mst, rst_pin_mst_oe
  );
endinterface

// [ebh_device.sv]
// device end: bus ownership, control pins, ready waits, reset pin
module ebh_device #(
  parameter int unsigned BANKS = ebh_pkg::EBH_BANKS
) (
  input wire logic clk,
  input wire logic rst,
  ebh_if.dev link,
  input wire logic acc_req,
  input wire logic acc_read,
  input wire logic [31:0] acc_addr,
  input wire logic [ebh_pkg::EBH_BANK_W-1:0] acc_bank,
  input wire logic [BANKS-1:0] bank_ready_en,
  input wire logic [ebh_pkg::EBH_OE_DLY_W*BANKS-1:0] bank_oe_delay,
  input wire logic hold_priority_select,
  input wire logic sys_reset_req,
  input wire logic dma3_eot_n,
  output logic acc_busy_q,
  output logic acc_done_q,
  output logic owner_q,
  output logic [1:0] ext_master_xfer_size_q,
  output logic ext_rw_q,
  output logic sys_reset_q
);
  typedef enum logic [1:0] {EBH_IDLE, EBH_OE_WAIT, EBH_XFER, EBH_HELD} ebh_state_t;
  ebh_state_t state_q;
  logic [ebh_pkg::EBH_OE_DLY_W-1:0] oe_cnt_q;
  logic rdy_use_q;
  logic read_q;
  logic [31:0] addr_q;
  logic hipri_q;
  logic [3:0] lo_cnt_q;
  logic [3:0] drv_cnt_q;
  logic ready_seen;

  function automatic logic [ebh_pkg::EBH_OE_DLY_W-1:0] oe_dly_of(input logic [ebh_pkg::EBH_BANK_W-1:0] b,
      input logic [ebh_pkg::EBH_OE_DLY_W*BANKS-1:0] f);
    oe_dly_of = f[b*ebh_pkg::EBH_OE_DLY_W +: ebh_pkg::EBH_OE_DLY_W];
  endfunction

  // ready ignored for banks without the enable
  assign ready_seen = !rdy_use_q || link.ready; // RULE_12

  // priority captured outside reset only
  always_ff @(posedge clk) begin
    if (rst) hipri_q <= 1'b0;
    else hipri_q <= !hold_priority_select; // RULE_15
  end

  // low priority hold waits until no local access is pending
  always_ff @(posedge clk) begin
    if (rst || sys_reset_q) begin
      state_q <= EBH_IDLE;
      oe_cnt_q <= '0;
      rdy_use_q <= 1'b0;
      read_q <= 1'b1;
      addr_q <= '0;
      acc_done_q <= 1'b0;
    end else begin
      acc_done_q <= 1'b0;
      unique case (state_q)
        EBH_IDLE: begin
          if (link.bus_hold_request && (hipri_q || !acc_req)) begin
            state_q <= EBH_HELD; // RULE_17
          end else if (acc_req) begin
            read_q <= acc_read; // RULE_05
            addr_q <= acc_addr; // RULE_06
            rdy_use_q <= bank_ready_en[acc_bank];
            oe_cnt_q <= oe_dly_of(acc_bank, bank_oe_delay);
            state_q <= EBH_OE_WAIT;
          end
        end
        EBH_OE_WAIT: begin
          if (oe_cnt_q == '0) state_q <= EBH_XFER; // RULE_09
          else oe_cnt_q <= oe_cnt_q - 1'b1;
        end
        EBH_XFER: begin
          if (ready_seen) begin // RULE_11
            acc_done_q <= 1'b1;
            state_q <= EBH_IDLE;
          end
        end
        EBH_HELD: begin
          if (!link.bus_hold_request) state_q <= EBH_IDLE; // RULE_02
        end
      endcase
    end
  end

  // grant and pin drivers all registered
  always_ff @(posedge clk) begin
    if (rst || sys_reset_q) begin
      link.bus_hold_grant <= 1'b0;
      owner_q <= 1'b1;
      acc_busy_q <= 1'b0;
    end else begin
      link.bus_hold_grant <= (state_q == EBH_HELD) && link.bus_hold_request; // RULE_03 RULE_04
      owner_q <= !((state_q == EBH_HELD) && link.bus_hold_request);
      acc_busy_q <= (state_q == EBH_OE_WAIT) || (state_q == EBH_XFER);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || sys_reset_q) begin
      link.addr_dev <= '0;
      link.addr_dev_oe <= 1'b1;
      link.rw_dev <= 1'b1;
      link.rw_dev_oe <= 1'b1;
      link.oe_n_dev <= 1'b1;
      link.oe_n_dev_oe <= 1'b1;
      link.dma3_dev <= 1'b1;
      link.dma3_dev_oe <= 1'b1;
    end else begin
      // address and direction share one register stage
      link.addr_dev <= addr_q; // RULE_06
      link.rw_dev <= read_q; // RULE_05
      link.oe_n_dev <= !(read_q && state_q == EBH_XFER); // RULE_08
      link.dma3_dev <= dma3_eot_n;
      link.addr_dev_oe <= state_q != EBH_HELD;
      link.rw_dev_oe <= state_q != EBH_HELD; // RULE_07
      link.oe_n_dev_oe <= state_q != EBH_HELD; // RULE_10
      link.dma3_dev_oe <= state_q != EBH_HELD; // RULE_16
    end
  end

  // size and direction from the master while it owns the bus
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_master_xfer_size_q <= 2'h0;
      ext_rw_q <= 1'b1;
    end else if (state_q == EBH_HELD) begin
      ext_master_xfer_size_q <= {link.oe_pin, link.dma3_pin}; // RULE_10 RULE_16
      ext_rw_q <= link.rw_pin; // RULE_07
    end
  end

  // reset pin: count low input, drive low for eight cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      lo_cnt_q <= 4'h0;
      drv_cnt_q <= 4'h0;
      sys_reset_q <= 1'b0;
      link.rst_pin_dev <= 1'b1;
      link.rst_pin_dev_oe <= 1'b0;
    end else begin
      // own drive ignored in the count, else reset would retrigger itself
      if (drv_cnt_q != 4'h0 || link.rst_pin_dev_oe || link.rst_pin) lo_cnt_q <= 4'h0;
      else if (lo_cnt_q != ebh_pkg::EBH_RST_CNT_MAX) lo_cnt_q <= lo_cnt_q + 4'h1;
      if (drv_cnt_q != 4'h0) begin
        drv_cnt_q <= drv_cnt_q - 4'h1;
        sys_reset_q <= drv_cnt_q != 4'h1;
        link.rst_pin_dev_oe <= drv_cnt_q != 4'h1; // RULE_14
        link.rst_pin_dev <= drv_cnt_q == 4'h1;
      // seven lows counted plus the eighth low sampled now
      end else if (sys_reset_req || (lo_cnt_q == ebh_pkg::EBH_RST_CYCLES - 4'h1 &&
          !link.rst_pin && !link.rst_pin_dev_oe)) begin // RULE_13
        drv_cnt_q <= ebh_pkg::EBH_RST_CYCLES;
        sys_reset_q <= 1'b1;
        link.rst_pin_dev_oe <= 1'b1; // RULE_14
        link.rst_pin_dev <= 1'b0;
      end
    end
  end
endmodule

// [ebh_master.sv]
// external master end: requests the bus and paces device cycles
module ebh_master (
  input wire logic clk,
  input wire logic rst,
  ebh_if.mst link,
  input wire logic want_bus,
  input wire logic xfer_read,
  input wire logic [1:0] xfer_size,
  input wire logic slow_ready,
  input wire logic reset_req,
  output logic granted_q,
  output logic reset_seen_q
);
  logic [3:0] rst_cnt_q;

  always_ff @(posedge clk) begin
    if (rst) link.bus_hold_request <= 1'b0;
    else link.bus_hold_request <= want_bus; // RULE_01 RULE_02
  end

  // drive shared pins only once grant is seen
  always_ff @(posedge clk) begin
    if (rst) begin
      granted_q <= 1'b0;
      link.rw_mst <= 1'b1;
      link.rw_mst_oe <= 1'b0;
      link.oe_mst <= 1'b0;
      link.oe_mst_oe <= 1'b0;
      link.dma3_mst <= 1'b0;
      link.dma3_mst_oe <= 1'b0;
      link.ready <= 1'b1;
    end else begin
      granted_q <= link.bus_hold_grant && want_bus;
      link.rw_mst <= xfer_read; // RULE_07
      link.oe_mst <= xfer_size[1]; // RULE_10
      link.dma3_mst <= xfer_size[0]; // RULE_16
      link.rw_mst_oe <= link.bus_hold_grant && want_bus;
      link.oe_mst_oe <= link.bus_hold_grant && want_bus;
      link.dma3_mst_oe <= link.bus_hold_grant && want_bus;
      link.ready <= !slow_ready; // RULE_11
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rst_cnt_q <= 4'h0;
      link.rst_pin_mst <= 1'b1;
      link.rst_pin_mst_oe <= 1'b0;
      reset_seen_q <= 1'b0;
    end else begin
      reset_seen_q <= !link.rst_pin;
      if (rst_cnt_q != 4'h0) begin
        rst_cnt_q <= rst_cnt_q - 4'h1;
        link.rst_pin_mst_oe <= rst_cnt_q != 4'h1; // RULE_13
        link.rst_pin_mst <= rst_cnt_q == 4'h1;
      end else if (reset_req) begin
        rst_cnt_q <= ebh_pkg::EBH_RST_CYCLES;
        link.rst_pin_mst_oe <= 1'b1;
        link.rst_pin_mst <= 1'b0;
      end
    end
  end
endmodule

// [ebh_link_sva.sv]
// assertions on the device/master pin link
module ebh_link_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_hold_request,
  input wire logic bus_hold_grant,
  input wire logic rw_dev,
  input wire logic rw_dev_oe,
  input wire logic oe_n_dev,
  input wire logic oe_n_dev_oe,
  input wire logic rst_pin_dev,
  input wire logic rst_pin_dev_oe,
  input wire logic rst_pin_mst,
  input wire logic rst_pin_mst_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic dev_low = rst_pin_dev_oe && !rst_pin_dev;
  wire logic mst_low = rst_pin_mst_oe && !rst_pin_mst;
  // bound covers a ready-paced access ahead of the grant
  a_grant_follows: assert property ($rose(bus_hold_request) |-> ##[2:200] bus_hold_grant) else $error("grant late");
  a_grant_cause: assert property ($rose(bus_hold_grant) |-> $past(bus_hold_request)) else $error("grant no request");
  a_grant_drop: assert property ($fell(bus_hold_request) |=> !bus_hold_grant) else $error("grant held");
  a_pins_released: assert property (bus_hold_grant |-> !rw_dev_oe && !oe_n_dev_oe) else $error("pins driven");
  a_pins_owned: assert property (!bus_hold_grant && !$past(bus_hold_grant) && !bus_hold_request |->
    rw_dev_oe && oe_n_dev_oe) else $error("pins not driven");
  a_oe_read_only: assert property (oe_n_dev_oe && !oe_n_dev |-> rw_dev) else $error("oe on write");
  a_reset_drive: assert property ($rose(dev_low) |-> dev_low[*8] ##1 !dev_low) else $error("reset drive len");
  a_ext_reset: assert property ($rose(mst_low) ##1 mst_low[*7] |-> ##[0:4] dev_low) else $error("no reset");
  cover property ($rose(bus_hold_grant));
  cover property ($rose(dev_low));
  cover property (oe_n_dev_oe && !oe_n_dev);
endmodule

// [external_bus_hold_control_test.sv]
// self-checking bench: device and master across the pin link
module external_bus_hold_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, acc_req = 1'b0, acc_read = 1'b1, hold_priority_select = 1'b0;
  logic sys_reset_req = 1'b0, dma3_eot_n = 1'b1, want_bus = 1'b0, xfer_read = 1'b0, slow_ready = 1'b0, reset_req = 1'b0;
  logic [31:0] acc_addr = 32'h0000_0000;
  logic [2:0] acc_bank = 3'h0;
  // banks 0 and 2 honour ready; oe delay equals bank number for banks 0 to 3, zero for banks 4 to 7
  logic [7:0] bank_ready_en = 8'h05;
  logic [15:0] bank_oe_delay = 16'h00E4;
  logic [1:0] xfer_size = 2'h0, ext_master_xfer_size_q;
  logic acc_busy_q, acc_done_q, owner_q, ext_rw_q, sys_reset_q, granted_q, reset_seen_q, oe_low;
  int num_errors = 0, check_count = 0, n;
  ebh_if link ();
  always #2.5 clk = ~clk;
  ebh_device u_ebh_device (.clk(clk), .rst(rst), .link(link), .acc_req(acc_req), .acc_read(acc_read),
    .acc_addr(acc_addr), .acc_bank(acc_bank), .bank_ready_en(bank_ready_en), .bank_oe_delay(bank_oe_delay),
    .hold_priority_select(hold_priority_select), .sys_reset_req(sys_reset_req), .dma3_eot_n(dma3_eot_n),
    .acc_busy_q(acc_busy_q), .acc_done_q(acc_done_q), .owner_q(owner_q),
    .ext_master_xfer_size_q(ext_master_xfer_size_q), .ext_rw_q(ext_rw_q), .sys_reset_q(sys_reset_q));
  ebh_master u_ebh_master (.clk(clk), .rst(rst), .link(link), .want_bus(want_bus), .xfer_read(xfer_read),
    .xfer_size(xfer_size), .slow_ready(slow_ready), .reset_req(reset_req), .granted_q(granted_q),
    .reset_seen_q(reset_seen_q));
  ebh_link_sva u_ebh_link_sva (.clk(clk), .rst(rst), .bus_hold_request(link.bus_hold_request),
    .bus_hold_grant(link.bus_hold_grant), .rw_dev(link.rw_dev), .rw_dev_oe(link.rw_dev_oe),
    .oe_n_dev(link.oe_n_dev), .oe_n_dev_oe(link.oe_n_dev_oe), .rst_pin_dev(link.rst_pin_dev),
    .rst_pin_dev_oe(link.rst_pin_dev_oe), .rst_pin_mst(link.rst_pin_mst), .rst_pin_mst_oe(link.rst_pin_mst_oe));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic access(input logic rd, input logic [2:0] bank);
    @(negedge clk);
    acc_read = rd;
    acc_bank = bank;
    acc_addr = {27'h0, bank, 2'h0};
    slow_ready = 1'b1;
    acc_req = 1'b1;
    oe_low = 1'b0;
    for (n = 0; n < 99 && acc_done_q !== 1'b1; n++) begin
      @(negedge clk);
      if (n == bank + 2) slow_ready = 1'b0;
      if (link.oe_pin === 1'b0) oe_low = 1'b1;
      if (acc_busy_q === 1'b1) chk("rw pin", rd, link.rw_pin);
    end
    acc_req = 1'b0;
    chk("oe seen", rd, oe_low);
    if (bank_ready_en[bank]) chk("waited", 1, n > bank + 3);
    else chk("cycles", bank + 3, n);
  endtask
  task automatic hold(input logic [1:0] sz);
    want_bus = 1'b1;
    xfer_size = sz;
    xfer_read = sz[0];
    for (n = 0; n < 50 && granted_q !== 1'b1; n++) @(negedge clk);
    repeat (3) @(negedge clk);
    chk("grant", 1'b1, link.bus_hold_grant);
    chk("size", sz, ext_master_xfer_size_q);
    chk("dir", sz[0], ext_rw_q);
    want_bus = 1'b0;
    repeat (3) @(negedge clk);
    chk("grant off", 1'b0, link.bus_hold_grant);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int b = 0; b < 4; b++) access(b[0], b[2:0]);
    for (int s = 0; s < 4; s++) hold(s[1:0]);
    for (int p = 0; p < 2; p++) begin
      hold_priority_select = p[0];
      @(negedge clk);
      acc_bank = 3'h1;
      // request leads by one cycle so both meet the idle state together
      want_bus = 1'b1;
      @(negedge clk);
      acc_req = 1'b1;
      for (n = 0; n < 50 && acc_done_q !== 1'b1 && granted_q !== 1'b1; n++) @(negedge clk);
      chk("first", p[0], acc_done_q);
      if (acc_done_q === 1'b1) acc_req = 1'b0;
      repeat (4) @(negedge clk);
      chk("held busy", 1'b0, acc_busy_q);
      want_bus = 1'b0;
      for (n = 0; n < 50 && acc_req === 1'b1; n++) begin
        @(negedge clk);
        if (acc_done_q === 1'b1) acc_req = 1'b0;
      end
      chk("resumed", 1'b0, acc_req);
      repeat (4) @(negedge clk);
    end
    sys_reset_req = 1'b1;
    @(negedge clk);
    sys_reset_req = 1'b0;
    for (n = 0; n < 20 && link.rst_pin !== 1'b0; n++) @(negedge clk);
    for (n = 0; n < 30 && link.rst_pin === 1'b0; n++) @(negedge clk);
    chk("drive", ebh_pkg::EBH_RST_CYCLES, n);
    repeat (10) @(negedge clk);
    reset_req = 1'b1;
    @(negedge clk);
    reset_req = 1'b0;
    for (n = 0; n < 40 && sys_reset_q !== 1'b1; n++) @(negedge clk);
    chk("sys reset", 1'b1, sys_reset_q);
    chk("seen", 1'b1, reset_seen_q);
    print_verdict();
  end
  // whole run is under two hundred cycles
  initial begin
    #20000;
    num_errors++;
    print_verdict();
  end
endmodule
